// [rtl/wwr_edge_sync.sv]
// synchroniser and falling-edge detector for the watchdog input
`timescale 1ns/10ps
module wwr_edge_sync import wwr_pkg::*; (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic srst,
	// pin
	input  wire logic watchdog_edge_in,
	// event
	output logic      fall
);

	logic       meta;
	logic [1:0] hist;
	logic       next_meta;
	logic [1:0] next_hist;
	logic       next_fall;

	always_comb begin
		next_meta = watchdog_edge_in;
		next_hist = {hist[0], meta};
		next_fall = hist[1] & ~hist[0];
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			meta <= 1'b1;
			hist <= 2'h3;
			fall <= 1'b0;
		end else begin
			meta <= next_meta;
			hist <= next_hist;
			fall <= next_fall;
		end
	end

endmodule // wwr_edge_sync

// [rtl/wwr_pkg.sv]
// package: constants, states and carriers for the wakeup watchdog reset timer
package wwr_pkg;

	// timebase and resistor scaling (times in ns)
	localparam int unsigned CLK_PERIOD_NS  = 50;
	localparam int unsigned RES_NOM_OHM    = 60000;
	// wake period 4.17e-7 s/ohm -> ns per kohm
	localparam int unsigned WAKE_NS_PER_KOHM  = 417000;
	// release-to-wake 2.08e-7 s/ohm
	localparam int unsigned DELAY_NS_PER_KOHM = 208000;
	// reset delay 5.21e-8 s/ohm
	localparam int unsigned RST_NS_PER_KOHM   = 52100;
	localparam int unsigned RES_WIDTH         = 20;
	localparam int unsigned CNT_WIDTH         = 24;
	// duty cycle
	localparam int unsigned DUTY_PCT       = 50;
	localparam int unsigned DUTY_MIN_PCT   = 45;
	localparam int unsigned DUTY_MAX_PCT   = 55;
	// response limits (ns, and the max in cycles)
	localparam int unsigned WD_RESP_TYP_NS  = 2000;
	localparam int unsigned WD_RESP_MAX_NS  = 5000;
	localparam int unsigned WD_RESP_MAX_CYC = (WD_RESP_MAX_NS / CLK_PERIOD_NS);
	// nominal figures at the nominal resistor
	localparam int unsigned WAKE_NOM_US     = 25000;
	localparam int unsigned DELAY_NOM_US    = 12500;
	localparam int unsigned SYNC_STAGES     = 2;

	// controller states, gray on HOLDOFF to HIGH, HIGH to LOW and LOW to RSTWAIT
	typedef enum logic [2:0] {
		WWR_ST_RESET   = 3'h0,
		WWR_ST_HOLDOFF = 3'h1,
		WWR_ST_HIGH    = 3'h3,
		WWR_ST_LOW     = 3'h2,
		WWR_ST_RSTWAIT = 3'h6
	} wwr_state_t;

	// timing terminal counts
	typedef struct packed {
		logic [CNT_WIDTH-1:0] wake_half;
		logic [CNT_WIDTH-1:0] holdoff;
		logic [CNT_WIDTH-1:0] rst_delay;
	} wwr_terms_t;

	// cycles for a resistor value, never under one
	function automatic logic [CNT_WIDTH-1:0] wwr_cycles(input logic [RES_WIDTH-1:0] res_ohm,
		input int unsigned ns_per_kohm);
		logic [63:0] prod;
		prod = (64'(res_ohm) * 64'(ns_per_kohm)) / (64'(1000) * 64'(CLK_PERIOD_NS));
		if (prod == 64'h0) begin
			prod = 64'h1;
		end
		return prod[CNT_WIDTH-1:0];
	endfunction

endpackage

// [rtl/wwr_timebase.sv]
// terminal counts derived from the timing resistor value
`timescale 1ns/10ps
module wwr_timebase import wwr_pkg::*; (
	// clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 srst,
	// resistor setting
	input  wire logic [RES_WIDTH-1:0] timing_resistor,
	// terms
	output wwr_terms_t                terms
);

	wwr_terms_t next_terms;

	// scale each interval with the resistor
	always_comb begin
		next_terms.wake_half = wwr_cycles(timing_resistor, WAKE_NS_PER_KOHM * DUTY_PCT / 100);
		next_terms.holdoff   = wwr_cycles(timing_resistor, DELAY_NS_PER_KOHM);
		next_terms.rst_delay = wwr_cycles(timing_resistor, RST_NS_PER_KOHM);
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			terms <= '{default: CNT_WIDTH'(1)};
		end else begin
			terms <= next_terms;
		end
	end

endmodule // wwr_timebase

// [rtl/wwr_top.sv]
// wakeup square wave, watchdog check and reset generation
`timescale 1ns/10ps
module wwr_top import wwr_pkg::*; (
	// clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 srst,
	// regulator and resistor
	input  wire logic                 undervolt,
	input  wire logic [RES_WIDTH-1:0] timing_resistor,
	// processor side
	input  wire logic                 watchdog_edge_in,
	output logic                      wake_out,
	output logic                      reset_out_n,
	// status
	output logic                      wdog_timeout
);

	wwr_terms_t           terms;
	logic                 wd_fall;
	wwr_state_t           state;
	wwr_state_t           next_state;
	logic [CNT_WIDTH-1:0] cnt;
	logic [CNT_WIDTH-1:0] next_cnt;
	logic                 seen;
	logic                 next_seen;
	logic                 next_wake;
	logic                 next_rst_n;
	logic                 next_timeout;

	// true on the last cycle of an interval of term cycles
	function automatic logic term_hit(input logic [CNT_WIDTH-1:0] c, input logic [CNT_WIDTH-1:0] term);
		return (c + CNT_WIDTH'(1)) >= term;
	endfunction

	wwr_timebase u_timebase (
		.ref_clk         (ref_clk),
		.srst            (srst),
		.timing_resistor (timing_resistor),
		.terms           (terms)
	);

	wwr_edge_sync u_edge (
		.ref_clk          (ref_clk),
		.srst             (srst),
		.watchdog_edge_in (watchdog_edge_in),
		.fall             (wd_fall)
	);

	always_comb begin
		next_state   = state;
		next_cnt     = cnt + CNT_WIDTH'(1);
		next_seen    = seen;
		next_wake    = 1'b0;
		next_rst_n   = 1'b1;
		next_timeout = 1'b0;
		case (state)
			WWR_ST_RESET: begin
				next_rst_n = 1'b0;
				next_cnt   = '0;
				if (!undervolt) begin
					next_state = WWR_ST_RSTWAIT;
				end
			end
			WWR_ST_RSTWAIT: begin
				next_rst_n = 1'b0;
				if (undervolt) begin
					next_cnt = '0;
				end else if (term_hit(cnt, terms.rst_delay)) begin
					next_rst_n = 1'b1;
					next_cnt   = '0;
					next_state = WWR_ST_HOLDOFF;
				end
			end
			WWR_ST_HOLDOFF: begin
				if (term_hit(cnt, terms.holdoff)) begin
					next_cnt   = '0;
					next_seen  = 1'b0;
					next_wake  = 1'b1;
					next_state = WWR_ST_HIGH;
				end
			end
			WWR_ST_HIGH: begin
				next_wake = 1'b1;
				if (wd_fall && !seen) begin
					next_seen = 1'b1;
					next_wake = 1'b0;
				end else if (seen) begin
					next_wake = 1'b0;
				end
				if (term_hit(cnt, terms.wake_half)) begin
					next_cnt   = '0;
					next_wake  = 1'b0;
					next_state = WWR_ST_LOW;
				end
			end
			WWR_ST_LOW: begin
				if (wd_fall) begin
					next_seen = 1'b1;
				end
				if (term_hit(cnt, terms.wake_half)) begin
					next_cnt = '0;
					if (seen || wd_fall) begin
						next_seen  = 1'b0;
						next_wake  = 1'b1;
						next_state = WWR_ST_HIGH;
					end else begin
						next_rst_n   = 1'b0;
						next_timeout = 1'b1;
						next_state   = WWR_ST_RSTWAIT;
					end
				end
			end
			default: begin
				next_state = WWR_ST_RESET;
				next_cnt   = '0;
				next_rst_n = 1'b0;
			end
		endcase
		if (undervolt) begin
			next_state = WWR_ST_RSTWAIT;
			next_cnt   = '0;
			next_rst_n = 1'b0;
			next_wake  = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state        <= WWR_ST_RESET;
			cnt          <= '0;
			seen         <= 1'b0;
			wake_out     <= 1'b0;
			reset_out_n  <= 1'b0;
			wdog_timeout <= 1'b0;
		end else begin
			state        <= next_state;
			cnt          <= next_cnt;
			seen         <= next_seen;
			wake_out     <= next_wake;
			reset_out_n  <= next_rst_n;
			wdog_timeout <= next_timeout;
		end
	end

endmodule // wwr_top

// [tb/test_wwr_top.sv]
// testbench for the wakeup watchdog reset timer
`timescale 1ns/10ps
module test_wwr_top;
	import wwr_pkg::*;
	logic                 ref_clk = 1'b0;
	logic                 srst = 1'b1;
	logic                 undervolt = 1'b1;
	logic [RES_WIDTH-1:0] timing_resistor = 20'h001F4;
	logic [1:0]           mode = 2'h1;
	logic [15:0]          dly = 16'h0000;
	logic                 watchdog_edge_in, wake_out, reset_out_n, wdog_timeout;
	int                   err_total = 0, n_tests = 0, cyc = 0, t;
	wwr_top wwr_top_i (.ref_clk, .srst, .undervolt, .timing_resistor, .watchdog_edge_in, .wake_out,
		.reset_out_n, .wdog_timeout);
	wwr_cpu_model wwr_cpu_model_i (.ref_clk, .wake_out, .mode, .dly, .watchdog_edge_in);
	initial forever #25 ref_clk = ~ref_clk;
	function automatic int half();
		return int'(timing_resistor) * 208500 / 50000;
	endfunction
	function automatic int hold();
		return int'(timing_resistor) * 208000 / 50000;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %0d exp %0d", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("errors %0d checks %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			give_verdict();
		end
	end
	initial begin
		t = $urandom(68226);
		repeat (10) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (50) @(posedge ref_clk);
		chk(reset_out_n, 1'b0);
		dly <= 16'(half() + 100 + $urandom % 500);
		undervolt <= 1'b0;
		@(posedge reset_out_n);
		t = cyc;
		@(posedge wake_out);
		chk(cyc - t, hold());
		t = cyc;
		@(negedge wake_out);
		chk(cyc - t, half());
		@(posedge wake_out);
		chk(cyc - t, 2 * half());
		@(negedge watchdog_edge_in);
		mode <= 2'h0;
		dly <= 16'(20 + $urandom % 1000);
		@(negedge watchdog_edge_in);
		t = cyc;
		@(negedge wake_out);
		chk(cyc - t <= WD_RESP_MAX_CYC, 1'b1);
		mode <= 2'h3;
		@(posedge wake_out);
		repeat (2) @(posedge ref_clk);
		mode <= 2'h2;
		@(posedge wake_out);
		chk(reset_out_n, 1'b1);
		@(posedge wdog_timeout);
		@(negedge ref_clk);
		chk({reset_out_n, wake_out}, 2'h0);
		@(posedge reset_out_n);
		mode <= 2'h0;
		t = cyc;
		@(posedge wake_out);
		chk(cyc - t, hold());
		repeat (200) @(posedge ref_clk);
		undervolt <= 1'b1;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		chk({reset_out_n, wake_out}, 2'h0);
		repeat (20 + $urandom % 100) @(posedge ref_clk);
		undervolt <= 1'b0;
		@(posedge reset_out_n);
		t = cyc;
		@(posedge wake_out);
		chk(cyc - t, hold());
		give_verdict();
	end
endmodule // test_wwr_top

// [tb/wwr_cpu_model.sv]
// processor model answering wake rises with watchdog pulses
`timescale 1ns/10ps
module wwr_cpu_model (
	input wire logic        ref_clk,
	input wire logic        wake_out,
	input wire logic [1:0]  mode,
	input wire logic [15:0] dly,
	output logic            watchdog_edge_in
);
	logic [1:0]  m;
	logic [15:0] d;
	// low and high each 5 us
	task automatic pulse();
		watchdog_edge_in <= 1'b0;
		repeat (100) @(posedge ref_clk);
		watchdog_edge_in <= 1'b1;
		repeat (100) @(posedge ref_clk);
	endtask
	initial begin
		watchdog_edge_in = 1'b1;
		forever begin
			@(posedge wake_out);
			m = mode;
			d = dly;
			// mode 2 silent, mode 3 double pulse
			if (m != 2'h2) begin
				repeat (d) @(posedge ref_clk);
				pulse();
				if (m == 2'h3) pulse();
			end
		end
	end
endmodule // wwr_cpu_model

// [tb/wwr_top_props.sv]
// checker for wake and reset timing
`timescale 1ns/10ps
module wwr_top_props import wwr_pkg::*; (
	input wire logic                 ref_clk,
	input wire logic                 srst,
	input wire logic                 undervolt,
	input wire logic [RES_WIDTH-1:0] timing_resistor,
	input wire logic                 watchdog_edge_in,
	input wire logic                 wake_out,
	input wire logic                 reset_out_n,
	input wire logic                 wdog_timeout
);
	logic [63:0] r, h, p, d, cnt, rc;
	assign r = 64'(timing_resistor);
	assign h = r * 208000 / 50000;
	assign p = 2 * (r * 208500 / 50000);
	assign d = r * 52100 / 50000;
	// cycles since release, cycles of reset with good supply
	always_ff @(posedge ref_clk) begin
		cnt <= (srst || !reset_out_n) ? 64'h0 : cnt + 64'h1;
		rc  <= (srst || undervolt || reset_out_n) ? 64'h0 : rc + 64'h1;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	a_wake_rst_low:
		assert property (!reset_out_n |-> !wake_out) else $error("wake high in reset");
	a_uv_holds_rst:
		assert property (undervolt |=> !reset_out_n) else $error("reset not held");
	a_uv_wake_fall:
		assert property ($rose(undervolt) |-> ##[1:100] !wake_out) else $error("wake slow on uv");
	a_wd_wake_fall:
		assert property ($fell(watchdog_edge_in) && wake_out |-> ##[1:100] !wake_out) else $error("wake slow");
	a_timeout_rst:
		assert property (wdog_timeout |-> ##[0:1] !reset_out_n) else $error("no timeout reset");
	a_timeout_pulse:
		assert property (wdog_timeout |=> !wdog_timeout) else $error("timeout too long");
	a_wake_phase:
		assert property ($rose(wake_out) |-> cnt >= h && (cnt - h) % p == 0) else $error("wake rise off");
	a_rst_delay:
		assert property ($rose(reset_out_n) |-> rc >= d && rc <= d + 2) else $error("reset delay off");
endmodule // wwr_top_props
bind wwr_top wwr_top_props wwr_top_props_i (.ref_clk, .srst, .undervolt, .timing_resistor,
	.watchdog_edge_in, .wake_out, .reset_out_n, .wdog_timeout);
